//--- hdl/cix_core.sv
// execution core for increment-skip, trap, or, special page and long call
// assumes program memory outside returns the word at pc combinationally
`timescale 1ns/1ps
`include "cix_regs.svh"
`default_nettype none

module cix_core #(
    parameter int STACK_DEPTH = 4
) (
    input wire logic clock, // 250 MHz core clock
    input wire logic rst_n, // synchronous reset, active low
    input wire logic [`CIX_INSTR_W-1:0] instr_word, // word fetched at pc
    input wire logic data_load_en, // preload strobe for data registers
    input wire logic [5:0] data_load_addr, // preload address
    input wire logic [`CIX_DATA_W-1:0] data_load_val, // preload value
    input wire logic [5:0] data_peek_addr, // observation address
    output logic [`CIX_DATA_W-1:0] data_peek_val, // data register at peek address
    output logic [`CIX_PC_W-1:0] pc, // program counter
    output logic [`CIX_DATA_W-1:0] working_register, // accumulator
    output logic zero_flag, // status zero flag
    output logic [$clog2(STACK_DEPTH)-1:0] stack_ptr, // next free stack slot
    output logic [`CIX_PC_W-1:0] stack_top, // last pushed address
    output logic [`CIX_NUM_SPECIAL*`CIX_DATA_W-1:0] special_page, // flat special page
    output logic busy // sequencer outside exec state
);

    localparam int SPW = $clog2(STACK_DEPTH);

    // =================================================================
    // state record
    typedef struct packed {
        cix_pkg::cix_fsm_t fsm;
        logic [`CIX_PC_W-1:0] pc;
        logic [`CIX_PC_W-1:0] target;
        logic [`CIX_DATA_W-1:0] wreg;
        logic zf;
        logic [SPW-1:0] sp;
        logic [STACK_DEPTH-1:0][`CIX_PC_W-1:0] stack;
        logic [`CIX_NUM_DATA-1:0][`CIX_DATA_W-1:0] data;
        logic [`CIX_NUM_SPECIAL-1:0][`CIX_DATA_W-1:0] special;
    } cix_state_t;

    cix_state_t s_r;
    cix_state_t s_nxt;

    // =================================================================
    // decode
    function automatic cix_pkg::cix_op_t cix_decode(input logic [`CIX_INSTR_W-1:0] w);
        cix_pkg::cix_op_t o;
        o = cix_pkg::cix_op_nop;
        if (w[`CIX_CALL_MSB:`CIX_CALL_LSB] == `CIX_CALL_TAG)
            o = cix_pkg::cix_op_call;
        else if (w[`CIX_CLS_MSB:`CIX_CLS_LSB] == `CIX_CLS_INC)
            o = cix_pkg::cix_op_inc;
        else if (w[`CIX_CLS_MSB:`CIX_CLS_LSB] == `CIX_CLS_ORR)
            o = cix_pkg::cix_op_orr;
        else if (w[`CIX_CLS_MSB:`CIX_CLS_LSB] == `CIX_CLS_ORI)
            o = cix_pkg::cix_op_ori;
        else if (w[`CIX_CLS_MSB:`CIX_CLS_LSB] == `CIX_CLS_RDS)
            o = cix_pkg::cix_op_rds;
        else if (w[`CIX_CLS_MSB:`CIX_CLS_LSB] == `CIX_CLS_WRS)
            o = cix_pkg::cix_op_wrs;
        else if (w[`CIX_CLS_MSB:`CIX_CLS_LSB] == `CIX_CLS_TRAP)
            o = cix_pkg::cix_op_trap;
        return o;
    endfunction

    // operand fields and results
    cix_pkg::cix_op_t op;
    logic [5:0] reg_addr;
    logic [3:0] sp_idx;
    logic dest_reg;
    logic exec_now;
    logic [`CIX_DATA_W-1:0] inc_sum;
    logic [`CIX_DATA_W-1:0] or_reg_val;
    logic [`CIX_DATA_W-1:0] or_imm_val;
    logic [`CIX_PC_W-1:0] pc_inc;

    assign op = cix_decode(instr_word);
    assign reg_addr = instr_word[`CIX_REG_MSB:0];
    assign sp_idx = instr_word[`CIX_IDX_MSB:0];
    assign dest_reg = instr_word[`CIX_DEST_BIT];
    assign exec_now = (s_r.fsm == cix_pkg::cix_exec);
    assign inc_sum = s_r.data[reg_addr] + 8'h01; // [RQ1]
    assign or_reg_val = s_r.wreg | s_r.data[reg_addr]; // [RQ5]
    assign or_imm_val = s_r.wreg | instr_word[`CIX_IMM_MSB:0]; // [RQ6]
    assign pc_inc = s_r.pc + 10'h001;

    // =================================================================
    // next state
    always_comb
    begin
        s_nxt = s_r;
        if (data_load_en)
            s_nxt.data[data_load_addr] = data_load_val;
        case (s_r.fsm)
            cix_pkg::cix_exec:
            begin
                s_nxt.pc = pc_inc;
                case (op)
                    cix_pkg::cix_op_inc:
                    begin
                        // sum to working register or back to the data register
                        if (dest_reg)
                            s_nxt.data[reg_addr] = inc_sum; // [RQ1]
                        else
                            s_nxt.wreg = inc_sum; // [RQ1]
                        // zero sum kills the prefetched word
                        if (inc_sum == 8'h00)
                            s_nxt.fsm = cix_pkg::cix_skip; // [RQ2]
                    end
                    cix_pkg::cix_op_orr:
                    begin
                        if (dest_reg)
                            s_nxt.data[reg_addr] = or_reg_val; // [RQ5]
                        else
                            s_nxt.wreg = or_reg_val; // [RQ5]
                        s_nxt.zf = (or_reg_val == 8'h00); // [RQ10]
                    end
                    cix_pkg::cix_op_ori:
                    begin
                        s_nxt.wreg = or_imm_val; // [RQ6]
                        s_nxt.zf = (or_imm_val == 8'h00); // [RQ10]
                    end
                    cix_pkg::cix_op_rds:
                    begin
                        s_nxt.wreg = s_r.special[sp_idx]; // [RQ7]
                    end
                    cix_pkg::cix_op_wrs:
                    begin
                        s_nxt.special[sp_idx] = s_r.wreg; // [RQ8]
                    end
                    cix_pkg::cix_op_trap:
                    begin
                        // push return address, hold pc until the vector load
                        s_nxt.stack[s_r.sp] = pc_inc; // [RQ3]
                        s_nxt.sp = s_r.sp + 1'b1; // [RQ3]
                        s_nxt.pc = s_r.pc;
                        s_nxt.fsm = cix_pkg::cix_trap1; // [RQ4]
                    end
                    cix_pkg::cix_op_call:
                    begin
                        s_nxt.stack[s_r.sp] = pc_inc; // [RQ9]
                        s_nxt.sp = s_r.sp + 1'b1; // [RQ9]
                        s_nxt.target = instr_word[`CIX_TGT_MSB:0]; // [RQ9]
                        s_nxt.pc = s_r.pc;
                        s_nxt.fsm = cix_pkg::cix_call2; // [RQ9]
                    end
                    default:
                    begin
                        s_nxt.pc = pc_inc;
                    end
                endcase
            end
            cix_pkg::cix_skip:
            begin
                // discarded word runs as a nop
                s_nxt.pc = pc_inc; // [RQ2]
                s_nxt.fsm = cix_pkg::cix_exec;
            end
            cix_pkg::cix_trap1:
            begin
                s_nxt.fsm = cix_pkg::cix_trap2; // [RQ4]
            end
            cix_pkg::cix_trap2:
            begin
                s_nxt.pc = `CIX_TRAP_VECTOR; // [RQ4]
                s_nxt.fsm = cix_pkg::cix_exec;
            end
            cix_pkg::cix_call2:
            begin
                s_nxt.pc = s_r.target; // [RQ9]
                s_nxt.fsm = cix_pkg::cix_exec;
            end
            default:
            begin
                s_nxt.fsm = cix_pkg::cix_exec;
            end
        endcase
    end

    // state register
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            s_r <= '0;
            s_r.pc <= `CIX_RESET_PC;
            s_r.fsm <= cix_pkg::cix_exec;
        end
        else
            s_r <= s_nxt;
    end

    // outputs straight from state
    assign pc = s_r.pc;
    assign working_register = s_r.wreg;
    assign zero_flag = s_r.zf;
    assign stack_ptr = s_r.sp;
    assign stack_top = s_r.stack[s_r.sp - 1'b1];
    assign special_page = s_r.special;
    assign data_peek_val = s_r.data[data_peek_addr];
    assign busy = !exec_now;

    // =================================================================
    // checks
    default clocking cix_cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    logic do_inc;
    logic do_orr;
    logic do_ori;
    logic do_rds;
    logic do_wrs;
    logic do_trap;
    logic do_call;
    assign do_inc = exec_now && op == cix_pkg::cix_op_inc && !data_load_en;
    assign do_orr = exec_now && op == cix_pkg::cix_op_orr && !data_load_en;
    assign do_ori = exec_now && op == cix_pkg::cix_op_ori;
    assign do_rds = exec_now && op == cix_pkg::cix_op_rds;
    assign do_wrs = exec_now && op == cix_pkg::cix_op_wrs;
    assign do_trap = exec_now && op == cix_pkg::cix_op_trap;
    assign do_call = exec_now && op == cix_pkg::cix_op_call;

    chk_inc_write_back: assert property (do_inc && dest_reg |=> // [RQ1]
        s_r.data[$past(reg_addr)] == $past(inc_sum) && $stable(s_r.wreg))
        else $error("increment result not written to data register");
    chk_inc_skip_nop: assert property (do_inc && inc_sum == 8'h00 |=> // [RQ2]
        s_r.fsm == cix_pkg::cix_skip ##1 s_r.fsm == cix_pkg::cix_exec
        && s_r.pc == $past(s_r.pc, 2) + 10'h002)
        else $error("zero increment did not skip one word");
    chk_trap_push: assert property (do_trap |=> // [RQ3]
        s_r.stack[$past(s_r.sp)] == $past(pc_inc) && s_r.sp == $past(s_r.sp) + 1'b1)
        else $error("trap return address not pushed");
    chk_trap_vector: assert property (do_trap |=> // [RQ4]
        $stable(s_r.pc) [*2] ##1 s_r.pc == `CIX_TRAP_VECTOR && exec_now)
        else $error("trap vector not loaded on third cycle");
    chk_or_reg_route: assert property (do_orr && !dest_reg |=> // [RQ5]
        s_r.wreg == $past(or_reg_val) && exec_now)
        else $error("or with register wrong result");
    chk_or_imm_value: assert property (do_ori |=> // [RQ6]
        s_r.wreg == $past(or_imm_val) && s_r.pc == $past(pc_inc))
        else $error("or immediate wrong result");
    chk_read_special: assert property (do_rds |=> // [RQ7]
        s_r.wreg == $past(s_r.special[sp_idx]) && $stable(s_r.zf))
        else $error("special read wrong or flag moved");
    chk_write_special: assert property (do_wrs |=> // [RQ8]
        s_r.special[$past(sp_idx)] == $past(s_r.wreg) && $stable(s_r.zf))
        else $error("special write wrong or flag moved");
    chk_call_target: assert property (do_call |=> // [RQ9]
        s_r.sp == $past(s_r.sp) + 1'b1 ##1 s_r.pc == $past(instr_word[`CIX_TGT_MSB:0], 2))
        else $error("long call target not loaded in two cycles");
    chk_zero_flag_set: assert property (do_orr || do_ori |=> // [RQ10]
        s_r.zf == ($past(do_orr) ? $past(or_reg_val) == 8'h00 : $past(or_imm_val) == 8'h00))
        else $error("zero flag does not match result");

    cov_inc_skip: cover property (do_inc && inc_sum == 8'h00);
    cov_trap_seq: cover property (do_trap ##3 exec_now);
    cov_call_seq: cover property (do_call ##2 do_rds);
    cov_or_zero: cover property (do_ori && or_imm_val == 8'h00);

endmodule

`default_nettype wire

//--- pkg/cix_regs.svh
// constants of the increment, trap, or, special page and call execution group
// assumes a 14-bit instruction word and a 10-bit program counter
// Functional notes
// [RQ1] increment a data register 0..63, result to working register or back by dest bit
// [RQ2] zero result of increment-skip discards prefetched word, runs a nop, two cycles
// [RQ3] software trap pushes program counter plus one onto the call stack first
// [RQ4] software trap then loads vector 0x001 into all ten bits; three cycles in all
// [RQ5] or working register with data register, route by dest bit, zero flag, one cycle
// [RQ6] or working register with 8-bit constant into working register, zero flag, one cycle
// [RQ7] copy special register 0..15 into working register in one cycle, flags kept
// [RQ8] load special register 0..15 from working register in one cycle, flags kept
// [RQ9] long call pushes program counter plus one, bumps stack pointer, loads target, two cycles
// [RQ10] zero flag set when the 8-bit result is zero, updated with the result
`ifndef CIX_REGS_SVH
`define CIX_REGS_SVH

// =====================================================================
// widths
`define CIX_INSTR_W 14
`define CIX_PC_W 10
`define CIX_DATA_W 8
`define CIX_NUM_DATA 64
`define CIX_NUM_SPECIAL 16

// =====================================================================
// instruction field positions
`define CIX_CLS_MSB 13
`define CIX_CLS_LSB 10
`define CIX_CALL_MSB 13
`define CIX_CALL_LSB 12
`define CIX_DEST_BIT 6
`define CIX_REG_MSB 5
`define CIX_IMM_MSB 7
`define CIX_IDX_MSB 3
`define CIX_TGT_MSB 9

// =====================================================================
// opcode classes
`define CIX_CLS_INC 4'h1
`define CIX_CLS_ORR 4'h2
`define CIX_CLS_ORI 4'h3
`define CIX_CLS_RDS 4'h4
`define CIX_CLS_WRS 4'h5
`define CIX_CLS_TRAP 4'h6
`define CIX_CALL_TAG 2'h2

// =====================================================================
// reset values and timing counts
`define CIX_RESET_PC 10'h000
`define CIX_TRAP_VECTOR 10'h001
`define CIX_TRAP_CYCLES 3
`define CIX_CALL_CYCLES 2
`define CIX_SKIP_CYCLES 2

`endif

//--- pkg/cix_pkg.sv
// types shared by the execution group
// assumes the constants header is included by the users
`default_nettype none

package cix_pkg;

    // =================================================================
    // decoded operation
    typedef enum logic [2:0] {
        cix_op_nop = 3'h0,
        cix_op_inc = 3'h1,
        cix_op_orr = 3'h2,
        cix_op_ori = 3'h3,
        cix_op_rds = 3'h4,
        cix_op_wrs = 3'h5,
        cix_op_trap = 3'h6,
        cix_op_call = 3'h7
    } cix_op_t;

    // =================================================================
    // sequencer states, gray along the exec-skip path and from trap1 back to exec
    typedef enum logic [2:0] {
        cix_exec = 3'b000,
        cix_skip = 3'b001,
        cix_trap1 = 3'b011,
        cix_trap2 = 3'b010,
        cix_call2 = 3'b110
    } cix_fsm_t;

endpackage

`default_nettype wire

//--- verif/cix_tb.sv
// self-checking bench for the increment, trap, or, special page and call group
// assumes the constants header on the include path and the package compiled first
`timescale 1ns/1ps
`include "cix_regs.svh"
`default_nettype none

`define CHK(nm, ex, gt) \
    begin \
        tests_run++; \
        if ((gt) !== (ex)) \
        begin \
            $display("Error %s expected %h seen %h", nm, ex, gt); \
            n_errors++; \
        end \
    end

module tb;
    // =================================================================
    // signals and counters
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [13:0] instr_word = 14'h0000;
    logic data_load_en = 1'b0;
    logic [5:0] data_load_addr = 6'h00;
    logic [7:0] data_load_val = 8'h00;
    logic [5:0] data_peek_addr = 6'h00;
    logic [7:0] data_peek_val;
    logic [9:0] pc;
    logic [7:0] working_register;
    logic zero_flag;
    logic [1:0] stack_ptr;
    logic [9:0] stack_top;
    logic [127:0] special_page;
    logic busy;
    logic [9:0] exp_pc = 10'h000;
    int n_errors = 0;
    int tests_run = 0;
    int cycles = 0;

    cix_core #(.STACK_DEPTH(4)) dut (
        .clock(clock), .rst_n(rst_n), .instr_word(instr_word),
        .data_load_en(data_load_en), .data_load_addr(data_load_addr),
        .data_load_val(data_load_val), .data_peek_addr(data_peek_addr),
        .data_peek_val(data_peek_val), .pc(pc), .working_register(working_register),
        .zero_flag(zero_flag), .stack_ptr(stack_ptr), .stack_top(stack_top),
        .special_page(special_page), .busy(busy)
    );

    // =================================================================
    // clock and hang guard
    always #2 clock = ~clock;

    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            n_errors++;
            results();
        end
    end

    // =================================================================
    // shared tasks
    task automatic results();
        if (n_errors == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // one instruction taken at the next edge, then settle
    task automatic exec(input logic [13:0] w);
        instr_word = w;
        @(posedge clock);
        #1;
        instr_word = 14'h0000;
        exp_pc = exp_pc + 10'h001;
    endtask

    // preload rides along with a nop, which still steps pc
    task automatic preload(input logic [5:0] a, input logic [7:0] v);
        data_load_en = 1'b1;
        data_load_addr = a;
        data_load_val = v;
        exec(14'h0000);
        data_load_en = 1'b0;
        data_peek_addr = a;
    endtask

    // =================================================================
    // scenarios
    task automatic t_inc();
        preload(6'h01, 8'h7f);
        exec({`CIX_CLS_INC, 3'h0, 1'b0, 6'h01});
        `CHK("inc wreg", 8'h80, working_register);
        `CHK("inc reg kept", 8'h7f, data_peek_val);
        `CHK("inc no skip", 1'b0, busy);
        preload(6'h05, 8'hff);
        exec({`CIX_CLS_INC, 3'h0, 1'b1, 6'h05});
        `CHK("inc reg", 8'h00, data_peek_val);
        `CHK("inc wreg kept", 8'h80, working_register);
        `CHK("skip busy", 1'b1, busy);
        // prefetched or-immediate must be dropped during the skip cycle
        exec({`CIX_CLS_ORI, 2'h0, 8'h0f});
        `CHK("skip pc", exp_pc, pc);
        `CHK("skip ignored", 8'h80, working_register);
        `CHK("skip done", 1'b0, busy);
    endtask

    task automatic t_trap();
        logic [9:0] a;
        a = exp_pc;
        exec({`CIX_CLS_TRAP, 10'h000});
        `CHK("trap push", a + 10'h001, stack_top);
        `CHK("trap sp", 2'h1, stack_ptr);
        `CHK("trap busy", 1'b1, busy);
        instr_word = {`CIX_CLS_ORI, 2'h0, 8'hf0};
        @(posedge clock);
        #1;
        `CHK("trap busy2", 1'b1, busy);
        @(posedge clock);
        #1;
        instr_word = 14'h0000;
        `CHK("trap vector", 10'h001, pc);
        `CHK("trap end", 1'b0, busy);
        `CHK("trap ignored", 8'h80, working_register);
        exp_pc = 10'h001;
    endtask

    task automatic t_call();
        logic [9:0] a;
        a = exp_pc;
        exec({2'b10, 2'b00, 10'h3ff});
        `CHK("call push", a + 10'h001, stack_top);
        `CHK("call sp", 2'h2, stack_ptr);
        `CHK("call busy", 1'b1, busy);
        instr_word = {`CIX_CLS_ORI, 2'h0, 8'h0f};
        @(posedge clock);
        #1;
        instr_word = 14'h0000;
        `CHK("call target", 10'h3ff, pc);
        `CHK("call end", 1'b0, busy);
        `CHK("call ignored", 8'h80, working_register);
        exp_pc = 10'h3ff;
    endtask

    task automatic t_or_special();
        exec({`CIX_CLS_RDS, 6'h00, 4'h0});
        exec({`CIX_CLS_ORI, 2'h0, 8'h00});
        `CHK("ori zero", 1'b1, zero_flag);
        exec({`CIX_CLS_WRS, 6'h00, 4'h3});
        `CHK("wrs flag kept", 1'b1, zero_flag);
        exec({`CIX_CLS_ORI, 2'h0, 8'h5a});
        `CHK("ori val", 8'h5a, working_register);
        `CHK("ori nz", 1'b0, zero_flag);
        exec({`CIX_CLS_WRS, 6'h00, 4'hf});
        `CHK("wrs val", 8'h5a, special_page[127:120]);
        exec({`CIX_CLS_ORI, 2'h0, 8'ha5});
        `CHK("ori ff", 8'hff, working_register);
        exec({`CIX_CLS_RDS, 6'h00, 4'h3});
        `CHK("rds zero", 8'h00, working_register);
        `CHK("rds flag kept", 1'b0, zero_flag);
        exec({`CIX_CLS_RDS, 6'h00, 4'hf});
        `CHK("rds val", 8'h5a, working_register);
        `CHK("rds pc", exp_pc, pc);
        preload(6'h3f, 8'h81);
        exec({`CIX_CLS_ORR, 3'h0, 1'b1, 6'h3f});
        `CHK("orr reg", 8'hdb, data_peek_val);
        `CHK("orr wreg kept", 8'h5a, working_register);
        `CHK("orr pc", exp_pc, pc);
        exec({`CIX_CLS_RDS, 6'h00, 4'h0});
        preload(6'h00, 8'h00);
        exec({`CIX_CLS_ORR, 3'h0, 1'b0, 6'h00});
        `CHK("orr zero", 1'b1, zero_flag);
        `CHK("orr wreg", 8'h00, working_register);
    endtask

    // =================================================================
    // main sequence
    initial
    begin
        repeat (20) @(posedge clock);
        #1;
        rst_n = 1'b1;
        `CHK("reset pc", 10'h000, pc);
        `CHK("reset busy", 1'b0, busy);
        t_inc();
        t_trap();
        t_call();
        t_or_special();
        results();
    end
endmodule

`default_nettype wire
